// >>> core/oat_pkg.sv
// shared constants for the output arbiter and threshold register bank
// assumes a 10 MHz system clock and four cores on the register path
package oat_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NCORE  = 4;
    localparam int NHS    = 5;
    localparam int NLS    = 6;
    localparam int NOUT   = NHS + NLS;
    localparam int NSTART = 6;
    localparam int NCUR   = 4;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int FLD_W  = 3;
    localparam int LVL_W  = 8;
    localparam int FILT_W = 12;
    localparam int TRIM_W = 6;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [8:0] ADDR_HS_DS  = 9'h18A;
    localparam logic [8:0] ADDR_HS_SRC = 9'h18B;
    localparam logic [8:0] ADDR_LS_DSA = 9'h18C;
    localparam logic [8:0] ADDR_LS_DSB = 9'h18D;
    localparam logic [8:0] ADDR_BLVL   = 9'h19B;
    localparam logic [8:0] ADDR_GRANT  = 9'h19C;
    localparam logic [8:0] ADDR_FILT   = 9'h19D;
    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int FILT_TYPE_BIT = 12;
    localparam int GRANT_W       = 4;
    localparam logic [15:0] RST_THR   = 16'h0000;
    localparam logic [7:0]  RST_BLVL  = 8'h00;
    localparam logic [3:0]  RST_GRANT = 4'h0;
    localparam logic [12:0] RST_FILT  = 13'h0000;
    // source threshold codes forced during bootstrap init
    localparam logic [2:0]  THR_BS_LOW  = 3'h1;
    localparam logic [2:0]  THR_BS_HIGH = 3'h2;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS          = 100;
    localparam int TRIM_SETTLE_NS  = 1000;
    localparam int TRIM_SETTLE_CYC = (TRIM_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        OAT_T_IDLE   = 3'b001,
        OAT_T_SETTLE = 3'b010,
        OAT_T_DECIDE = 3'b100
    } oat_trim_st_t;
endpackage

// >>> core/oat_glitch_filter.sv
// run-length glitch filter for the boost feedback input
// assumes smp is already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module oat_glitch_filter
    import oat_pkg::*;
#(
    parameter int CW = FILT_W
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // sample and setup
    input  wire logic          smp,
    input  wire logic          ftype,
    input  wire logic [CW-1:0] limit,
    // filtered level
    output logic               state
);
    logic [CW-1:0] cnt_r;

    // counts samples opposing the filtered level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            state <= 1'b0;
        end else if (smp != state) begin
            if (cnt_r >= limit) begin
                state <= smp;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end else if (ftype) begin
            cnt_r <= (cnt_r == '0) ? '0 : cnt_r - 1'b1;
        end else begin
            cnt_r <= '0;
        end
    end

    a_filter_flip: assert property (@(posedge clk) disable iff (sys_rst)
        (state != $past(state)) |-> ($past(cnt_r) >= $past(limit)))
        else $error("filtered level changed before count reached");
    a_filter_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (smp == state && !ftype) |=> cnt_r == '0)
        else $error("agreeing sample did not clear counter");
endmodule // oat_glitch_filter
`default_nettype wire

// >>> core/oat_offset_trim.sv
// successive approximation offset trim for a measurement amplifier
// assumes cmp_high is synchronised and high while trim is too large
`timescale 1ns/10ps
`default_nettype none
module oat_offset_trim
    import oat_pkg::*;
#(
    parameter int TW     = TRIM_W,
    parameter int SETTLE = TRIM_SETTLE_CYC
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // control
    input  wire logic          start,
    input  wire logic          cmp_high,
    // result
    output logic [TW-1:0]      trim,
    output logic               busy,
    output logic               done
);
    localparam int BW = $clog2(TW);
    oat_trim_st_t   st_r;
    logic [BW-1:0]  bit_r;
    logic [7:0]     cnt_r;

    // one bit per pass, dac settles before each decision
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= OAT_T_IDLE;
            trim <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            bit_r <= '0;
            cnt_r <= '0;
        end else begin
            case (st_r)
                OAT_T_IDLE: begin
                    done <= 1'b0;
                    if (start) begin
                        trim <= {1'b1, {(TW-1){1'b0}}};
                        bit_r <= BW'(TW - 1);
                        cnt_r <= '0;
                        busy <= 1'b1;
                        st_r <= OAT_T_SETTLE;
                    end
                end
                OAT_T_SETTLE: begin
                    if (cnt_r == 8'(SETTLE - 1)) begin
                        st_r <= OAT_T_DECIDE;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                OAT_T_DECIDE: begin
                    if (cmp_high) begin
                        trim[bit_r] <= 1'b0;
                    end
                    if (bit_r == '0) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        st_r <= OAT_T_IDLE;
                    end else begin
                        trim[bit_r - 1'b1] <= 1'b1;
                        bit_r <= bit_r - 1'b1;
                        cnt_r <= '0;
                        st_r <= OAT_T_SETTLE;
                    end
                end
                default: st_r <= OAT_T_IDLE;
            endcase
        end
    end

    a_trim_ends: assert property (@(posedge clk) disable iff (sys_rst)
        (start && !busy) |-> ##[1:100] done)
        else $error("offset trim did not finish in time");
endmodule // oat_offset_trim
`default_nettype wire

// >>> core/oat_output_arbiter.sv
// output arbiter, diagnosis and threshold register bank
// assumes core-side signals are on clk; pins and comparators are not
`timescale 1ns/10ps
`default_nettype none
module oat_output_arbiter
    import oat_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // register port
    input  wire logic                    spi_wr,
    input  wire logic                    spi_rd,
    input  wire logic [ADDR_W-1:0]       spi_addr,
    input  wire logic [DATA_W-1:0]       spi_wdata,
    output logic      [DATA_W-1:0]       spi_rdata,
    // core backdoor writes
    input  wire logic [NCORE-1:0]        core_wr,
    input  wire logic [NCORE*ADDR_W-1:0] core_addr,
    input  wire logic [NCORE*DATA_W-1:0] core_wdata,
    input  wire logic [NCORE-1:0]        core_lvl_wr,
    input  wire logic [NCORE*LVL_W-1:0]  core_lvl_data,
    input  wire logic                    cfg_lock,
    input  wire logic [NCORE*NOUT-1:0]   out_acc,
    // core command sets
    input  wire logic [NCORE*NOUT-1:0]   core_drive,
    input  wire logic [NCORE-1:0]        core_oc_req,
    // pins and analog feedback
    input  wire logic [NSTART-1:0]       start_inputs,
    input  wire logic [NOUT-1:0]         vds_fbk,
    input  wire logic [NCUR-1:0]         cur_fbk,
    input  wire logic                    boost_fbk,
    input  wire logic                    meas_cmp,
    input  wire logic                    boost_cmp,
    // bootstrap init state
    input  wire logic [NHS-1:0]          bs_init,
    input  wire logic [NHS-1:0]          bs_high_thr,
    // fan-out to cores
    output logic [NCORE*NSTART-1:0]      core_start_inputs,
    output logic [NCORE*NOUT-1:0]        core_vds_fbk,
    output logic [NCORE*NCUR-1:0]        core_cur_fbk,
    output logic [NCORE-1:0]             core_boost_fbk,
    // to analog modules
    output logic [NOUT-1:0]              drive,
    output logic [NOUT-1:0]              diag_fault,
    output logic [LVL_W-1:0]             boost_thr,
    output logic [NHS*FLD_W-1:0]         thr_hs_ds,
    output logic [NHS*FLD_W-1:0]         thr_hs_src,
    output logic [NLS*FLD_W-1:0]         thr_ls_ds,
    output logic [TRIM_W-1:0]            meas_trim,
    output logic [TRIM_W-1:0]            boost_trim,
    output logic                         trim_busy
);
    // ************************************************************
    // helpers
    // ************************************************************
    // replace only the 3-bit fields whose enable is set
    function automatic logic [15:0] fld_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [4:0]  en);
        logic [15:0] r;
        r = old_v;
        for (int i = 0; i < 5; i++) begin
            if (en[i]) begin
                r[i*FLD_W +: FLD_W] = new_v[i*FLD_W +: FLD_W];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int SW = NSTART + NOUT + NCUR + 3;
    logic [SW-1:0] meta_r;
    logic [SW-1:0] sync_r;
    logic [NSTART-1:0] start_s;
    logic [NOUT-1:0]   vds_s;
    logic [NCUR-1:0]   cur_s;
    logic              boost_s;
    logic              meas_cmp_s;
    logic              boost_cmp_s;

    // pins and comparators are asynchronous to clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {start_inputs, vds_fbk, cur_fbk, boost_fbk, meas_cmp, boost_cmp};
            sync_r <= meta_r;
        end
    end
    assign {start_s, vds_s, cur_s, boost_s, meas_cmp_s, boost_cmp_s} = sync_r;

    // ************************************************************
    // fan-out and merge
    // ************************************************************
    logic [NOUT-1:0] merged;
    logic            boost_filt;

    // a core drives only the outputs it owns
    always_comb begin
        merged = '0;
        for (int c = 0; c < NCORE; c++) begin
            merged = merged | (core_drive[c*NOUT +: NOUT] & out_acc[c*NOUT +: NOUT]);
        end
    end

    // every core sees the same copy of each input
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            core_start_inputs <= '0;
            core_vds_fbk <= '0;
            core_cur_fbk <= '0;
            core_boost_fbk <= '0;
            drive <= '0;
        end else begin
            core_start_inputs <= {NCORE{start_s}};
            core_vds_fbk <= {NCORE{vds_s}};
            core_cur_fbk <= {NCORE{cur_s}};
            core_boost_fbk <= {NCORE{boost_filt}};
            drive <= merged;
        end
    end

    // ************************************************************
    // automatic diagnosis
    // ************************************************************
    // an output commanded on with drain-source still high is flagged
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            diag_fault <= '0;
        end else begin
            diag_fault <= drive & vds_s;
        end
    end

    // ************************************************************
    // register bank
    // ************************************************************
    logic [15:0] hs_ds_r, hs_ds_nxt;
    logic [15:0] hs_src_r, hs_src_nxt;
    logic [15:0] ls_a_r, ls_a_nxt;
    logic [15:0] ls_b_r, ls_b_nxt;
    logic [7:0]  blvl_r, blvl_nxt;
    logic [3:0]  grant_r, grant_nxt;
    logic [12:0] filt_r, filt_nxt;

    // cores in index order, register port last so it wins
    always_comb begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [NOUT-1:0]   acc;
        a = '0;
        d = '0;
        acc = '0;
        hs_ds_nxt = hs_ds_r;
        hs_src_nxt = hs_src_r;
        ls_a_nxt = ls_a_r;
        ls_b_nxt = ls_b_r;
        blvl_nxt = blvl_r;
        grant_nxt = grant_r;
        filt_nxt = filt_r;
        for (int c = 0; c < NCORE; c++) begin
            a = core_addr[c*ADDR_W +: ADDR_W];
            d = core_wdata[c*DATA_W +: DATA_W];
            acc = out_acc[c*NOUT +: NOUT];
            if (core_lvl_wr[c] && grant_r[c]) begin
                blvl_nxt = core_lvl_data[c*LVL_W +: LVL_W];
            end
            if (core_wr[c]) begin
                case (a)
                    ADDR_HS_DS:  hs_ds_nxt = fld_merge(hs_ds_nxt, d, acc[4:0]);
                    ADDR_HS_SRC: hs_src_nxt = fld_merge(hs_src_nxt, d, acc[4:0]);
                    ADDR_LS_DSA: ls_a_nxt = fld_merge(ls_a_nxt, d, acc[9:5]);
                    ADDR_LS_DSB: ls_b_nxt = fld_merge(ls_b_nxt, d, {4'h0, acc[10]});
                    ADDR_GRANT: begin
                        if (!cfg_lock) begin
                            grant_nxt = d[GRANT_W-1:0];
                        end
                    end
                    ADDR_FILT: begin
                        if (!cfg_lock && grant_r[c]) begin
                            filt_nxt = d[12:0];
                        end
                    end
                    default: blvl_nxt = blvl_nxt;
                endcase
            end
        end
        if (spi_wr) begin
            case (spi_addr)
                ADDR_HS_DS:  hs_ds_nxt = {1'b0, spi_wdata[14:0]};
                ADDR_HS_SRC: hs_src_nxt = {1'b0, spi_wdata[14:0]};
                ADDR_LS_DSA: ls_a_nxt = {1'b0, spi_wdata[14:0]};
                ADDR_LS_DSB: ls_b_nxt = {13'h0000, spi_wdata[2:0]};
                ADDR_BLVL:   blvl_nxt = spi_wdata[LVL_W-1:0];
                ADDR_GRANT:  grant_nxt = spi_wdata[GRANT_W-1:0];
                ADDR_FILT:   filt_nxt = spi_wdata[12:0];
                default:     filt_nxt = filt_nxt;
            endcase
        end
    end

    // stored configuration
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_ds_r <= RST_THR;
            hs_src_r <= RST_THR;
            ls_a_r <= RST_THR;
            ls_b_r <= RST_THR;
            blvl_r <= RST_BLVL;
            grant_r <= RST_GRANT;
            filt_r <= RST_FILT;
        end else begin
            hs_ds_r <= hs_ds_nxt;
            hs_src_r <= hs_src_nxt;
            ls_a_r <= ls_a_nxt;
            ls_b_r <= ls_b_nxt;
            blvl_r <= blvl_nxt;
            grant_r <= grant_nxt;
            filt_r <= filt_nxt;
        end
    end

    // ************************************************************
    // effective thresholds and readback
    // ************************************************************
    logic [15:0] src_eff;

    // bootstrap init overrides the stored source thresholds
    always_comb begin
        src_eff = hs_src_r;
        for (int i = 0; i < NHS; i++) begin
            if (bs_init[i]) begin
                src_eff[i*FLD_W +: FLD_W] = bs_high_thr[i] ? THR_BS_HIGH : THR_BS_LOW;
            end
        end
    end

    // outputs to pre-drivers come from flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            thr_hs_ds <= '0;
            thr_hs_src <= '0;
            thr_ls_ds <= '0;
            boost_thr <= RST_BLVL;
        end else begin
            thr_hs_ds <= hs_ds_nxt[14:0];
            thr_hs_src <= src_eff[14:0];
            thr_ls_ds <= {ls_b_nxt[2:0], ls_a_nxt[14:0]};
            boost_thr <= blvl_nxt;
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spi_rdata <= '0;
        end else if (spi_rd) begin
            case (spi_addr)
                ADDR_HS_DS:  spi_rdata <= hs_ds_r;
                ADDR_HS_SRC: spi_rdata <= src_eff;
                ADDR_LS_DSA: spi_rdata <= ls_a_r;
                ADDR_LS_DSB: spi_rdata <= ls_b_r;
                ADDR_BLVL:   spi_rdata <= {8'h00, blvl_r};
                ADDR_GRANT:  spi_rdata <= {12'h000, grant_r};
                ADDR_FILT:   spi_rdata <= {3'h0, filt_r};
                default:     spi_rdata <= '0;
            endcase
        end
    end

    // ************************************************************
    // boost filter and offset trims
    // ************************************************************
    logic boost_auto_r;
    logic boost_auto_done_r;
    logic meas_busy;
    logic boost_busy;

    // fire the boost trim exactly once after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boost_auto_r <= 1'b0;
            boost_auto_done_r <= 1'b0;
            trim_busy <= 1'b0;
        end else begin
            boost_auto_r <= !boost_auto_done_r;
            boost_auto_done_r <= 1'b1;
            trim_busy <= meas_busy | boost_busy;
        end
    end

    oat_glitch_filter #(.CW(FILT_W)) u_bfilt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .smp     (boost_s),
        .ftype   (filt_r[FILT_TYPE_BIT]),
        .limit   (filt_r[FILT_W-1:0]),
        .state   (boost_filt)
    );

    oat_offset_trim u_mtrim (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .start    (|core_oc_req),
        .cmp_high (meas_cmp_s),
        .trim     (meas_trim),
        .busy     (meas_busy),
        .done     ()
    );

    oat_offset_trim u_btrim (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .start    (boost_auto_r),
        .cmp_high (boost_cmp_s),
        .trim     (boost_trim),
        .busy     (boost_busy),
        .done     ()
    );

    // ************************************************************
    // checks
    // ************************************************************
    a_fanout_copy: assert property (@(posedge clk) disable iff (sys_rst)
        core_start_inputs[NSTART-1:0] == core_start_inputs[NCORE*NSTART-1 -: NSTART])
        else $error("cores see different start inputs");
    a_merge_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (core_drive == '0) |=> (drive == '0))
        else $error("output driven with no core command");
    a_diag_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (drive[0] && vds_s[0]) |=> diag_fault[0])
        else $error("diagnosis missed high drain-source");
    a_lvl_port: assert property (@(posedge clk) disable iff (sys_rst)
        (spi_wr && spi_addr == ADDR_BLVL) |=> ##1 boost_thr == $past(spi_wdata[7:0], 2))
        else $error("boost level port write lost");
    a_lvl_denied: assert property (@(posedge clk) disable iff (sys_rst)
        (core_lvl_wr != '0 && (core_lvl_wr & grant_r) == '0 && !spi_wr) |=> blvl_r == $past(blvl_r))
        else $error("ungranted core changed boost level");
    a_lock_refuse: assert property (@(posedge clk) disable iff (sys_rst)
        (core_wr != '0 && cfg_lock && !spi_wr) |=> grant_r == $past(grant_r))
        else $error("locked grant register changed");
    a_thr_owner: assert property (@(posedge clk) disable iff (sys_rst)
        (core_wr == 4'h1 && !out_acc[0] && !spi_wr) |=> hs_ds_r[2:0] == $past(hs_ds_r[2:0]))
        else $error("core changed threshold it does not own");
    a_src_readback: assert property (@(posedge clk) disable iff (sys_rst)
        (spi_rd && spi_addr == ADDR_HS_SRC && bs_init[0] && !bs_high_thr[0])
        |=> spi_rdata[2:0] == THR_BS_LOW)
        else $error("source readback ignores bootstrap mask");
endmodule // oat_output_arbiter
`default_nettype wire

// >>> verif/oat_analog_model.sv
// analog side model: drain-source comparators and measurement amplifier
// assumes drive and meas_trim come from the arbiter on clk
`timescale 1ns/10ps
`default_nettype none
module oat_analog_model
    import oat_pkg::*;
#(
    parameter logic [TRIM_W-1:0] OFS = 6'h2A
) (
    // commands in
    input  wire logic [NOUT-1:0]   drive,
    input  wire logic [TRIM_W-1:0] meas_trim,
    // comparator outputs
    output logic      [NOUT-1:0]   vds_fbk,
    output logic                   meas_cmp
);
    // faulty load: each comparator reads high while its output is driven
    assign vds_fbk  = drive;
    // amplifier reads high while the trim overshoots its offset
    assign meas_cmp = (meas_trim > OFS);
endmodule // oat_analog_model
`default_nettype wire

// >>> verif/tb_output_arbiter_threshold_config.sv
// bench for the output arbiter register bank, one task per scenario
// assumes oat_pkg and oat_analog_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_output_arbiter_threshold_config;
    import oat_pkg::*;
    localparam logic [TRIM_W-1:0] OFS = 6'h2A;
    logic clk = 0, sys_rst = 1, spi_wr = 0, spi_rd = 0, cfg_lock = 0, boost_cmp = 0;
    logic [ADDR_W-1:0]       spi_addr = 0;
    logic [DATA_W-1:0]       spi_wdata = 0, spi_rdata;
    logic [NCORE-1:0]        core_wr = 0, core_lvl_wr = 0, core_oc_req = 0, core_boost_fbk;
    logic [NCORE*ADDR_W-1:0] core_addr = 0;
    logic [NCORE*DATA_W-1:0] core_wdata = 0;
    logic [NCORE*LVL_W-1:0]  core_lvl_data = 0;
    logic [NCORE*NOUT-1:0]   out_acc = 0, core_drive = 0, core_vds_fbk;
    logic [NSTART-1:0]       start_inputs = 0;
    logic [NCUR-1:0]         cur_fbk = 0;
    logic [NHS-1:0]          bs_init = 0, bs_high_thr = 0;
    logic                    boost_fbk = 0;
    logic [NOUT-1:0]         vds_fbk, drive, diag_fault;
    logic [NCORE*NSTART-1:0] core_start_inputs;
    logic [NCORE*NCUR-1:0]   core_cur_fbk;
    logic [NHS*FLD_W-1:0]    thr_hs_ds, thr_hs_src;
    logic [NLS*FLD_W-1:0]    thr_ls_ds;
    logic [LVL_W-1:0]        boost_thr;
    logic [TRIM_W-1:0]       meas_trim, boost_trim;
    logic                    meas_cmp, trim_busy;
    int                      fail_count = 0, n_compared = 0, cyc = 0;
    oat_output_arbiter i_dut (.clk, .sys_rst, .spi_wr, .spi_rd, .spi_addr, .spi_wdata,
        .spi_rdata, .core_wr, .core_addr, .core_wdata, .core_lvl_wr, .core_lvl_data,
        .cfg_lock, .out_acc, .core_drive, .core_oc_req, .start_inputs, .vds_fbk,
        .cur_fbk, .boost_fbk, .meas_cmp, .boost_cmp, .bs_init,
        .bs_high_thr, .core_start_inputs, .core_vds_fbk, .core_cur_fbk,
        .core_boost_fbk, .drive, .diag_fault, .boost_thr, .thr_hs_ds, .thr_hs_src,
        .thr_ls_ds, .meas_trim, .boost_trim, .trim_busy);
    oat_analog_model #(.OFS(OFS)) i_ana (.drive, .meas_trim, .vds_fbk, .meas_cmp);
    always #50 clk = ~clk;
    // hang guard, far beyond the longest scenario
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // inputs always move 1 ns after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic spi(input logic w, input logic [8:0] a, input logic [15:0] d);
        spi_wr = w;
        spi_rd = !w;
        spi_addr = a;
        spi_wdata = d;
        tick(1);
        spi_wr = 0;
        spi_rd = 0;
        tick(1);
    endtask
    task automatic cw(input int c, input logic [8:0] a, input logic [15:0] d);
        core_addr[9*c+:9] = a;
        core_wdata[16*c+:16] = d;
        core_wr[c] = 1;
        tick(1);
        core_wr = 0;
        tick(1);
    endtask
    task automatic lw(input int c, input logic [7:0] d);
        core_lvl_data[8*c+:8] = d;
        core_lvl_wr[c] = 1;
        tick(1);
        core_lvl_wr = 0;
        tick(1);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 300 && trim_busy !== 1'b0; i++) tick(1);
    endtask
    task automatic t_regs;
        logic [8:0] al[8] = '{9'h18A, 9'h18B, 9'h18C, 9'h18D, 9'h19B, 9'h19C, 9'h19D, 9'h19A};
        foreach (al[i]) begin
            spi(0, al[i], 0);
            chk(spi_rdata, 16'h0000);
        end
        spi(1, ADDR_LS_DSB, 16'hFFFF);
        spi(0, ADDR_LS_DSB, 0);
        chk(spi_rdata, 16'h0007);
        chk(thr_ls_ds[17:15], 3'h7);
        spi(1, ADDR_FILT, 16'hFFFF);
        spi(0, ADDR_FILT, 0);
        chk(spi_rdata, 16'h1FFF);
        $display("done regs");
    endtask
    task automatic t_boost;
        spi(1, ADDR_BLVL, 16'hFF55);
        spi(0, ADDR_BLVL, 0);
        chk(spi_rdata, 16'h0055);
        chk(boost_thr, 8'h55);
        lw(2, 8'hAA);
        chk(boost_thr, 8'h55);
        spi(1, ADDR_GRANT, 16'h0004);
        lw(2, 8'hAA);
        chk(boost_thr, 8'hAA);
        cw(2, ADDR_BLVL, 16'h0011);
        chk(boost_thr, 8'hAA);
        cfg_lock = 1;
        cw(2, ADDR_GRANT, 16'h000F);
        cfg_lock = 0;
        spi(0, ADDR_GRANT, 0);
        chk(spi_rdata, 16'h0004);
        $display("done boost");
    endtask
    task automatic t_path;
        out_acc[11] = 1;
        cw(1, ADDR_HS_DS, 16'h7FFF);
        chk(thr_hs_ds, 15'h0007);
        cw(0, ADDR_HS_DS, 16'h0000);
        chk(thr_hs_ds, 15'h0007);
        start_inputs = 6'h2D;
        cur_fbk = 4'h9;
        core_drive = 44'h002 | (44'h1 << 11);
        tick(3);
        chk(core_start_inputs[23:18], 6'h2D);
        chk(core_start_inputs[5:0], 6'h2D);
        chk(core_cur_fbk[15:12], 4'h9);
        chk(drive, 11'h001);
        tick(2);
        chk(diag_fault, 11'h001);
        chk(core_vds_fbk[43:33], 11'h001);
        $display("done path");
    endtask
    task automatic t_trim;
        wait_idle();
        chk(boost_trim, 6'h3F);
        core_oc_req[1] = 1;
        tick(1);
        core_oc_req = 0;
        tick(2);
        chk(trim_busy, 1'b1);
        wait_idle();
        chk(meas_trim, OFS);
        $display("done trim");
    endtask
    task automatic t_src;
        spi(1, ADDR_HS_SRC, 16'h7FFF);
        bs_init = 5'h01;
        spi(0, ADDR_HS_SRC, 0);
        chk(spi_rdata, {13'h0FFF, THR_BS_LOW});
        bs_high_thr = 5'h01;
        spi(0, ADDR_HS_SRC, 0);
        chk(spi_rdata, {13'h0FFF, THR_BS_HIGH});
        chk(thr_hs_src, {12'hFFF, THR_BS_HIGH});
        bs_init = 5'h00;
        spi(0, ADDR_HS_SRC, 0);
        chk(spi_rdata, 16'h7FFF);
        $display("done src");
    endtask
    task automatic t_filt;
        spi(1, ADDR_FILT, 16'h0002);
        boost_fbk = 1;
        tick(2);
        boost_fbk = 0;
        tick(6);
        chk(core_boost_fbk, 4'h0);
        boost_fbk = 1;
        tick(5);
        chk(core_boost_fbk, 4'h0);
        tick(1);
        chk(core_boost_fbk, 4'hF);
        $display("done filt");
    endtask
    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        tick(6);
        sys_rst = 0;
        tick(3);
        chk(trim_busy, 1'b1);
        t_regs();
        t_boost();
        t_path();
        t_src();
        t_filt();
        t_trim();
        stop_test();
    end
endmodule // tb_output_arbiter_threshold_config
`default_nettype wire
